/* File: hdl/tmr_pkg.sv */
// Package for the timer interrupt, low-power and control-one block
package tmr_pkg;
  // Register map (index on the plain register port)
  localparam logic [3:0] ADDR_CTRL_ONE   = 4'h0;
  localparam logic [3:0] ADDR_FLAGS      = 4'h1;
  localparam logic [3:0] ADDR_CNT_HI     = 4'h2;
  localparam logic [3:0] ADDR_CNT_LO     = 4'h3;
  localparam logic [3:0] ADDR_CAP1_HI    = 4'h4;
  localparam logic [3:0] ADDR_CAP1_LO    = 4'h5;
  localparam logic [3:0] ADDR_CAP2_HI    = 4'h6;
  localparam logic [3:0] ADDR_CAP2_LO    = 4'h7;
  localparam logic [3:0] ADDR_CMP1_HI    = 4'h8;
  localparam logic [3:0] ADDR_CMP1_LO    = 4'h9;
  localparam logic [3:0] ADDR_CMP2_HI    = 4'hA;
  localparam logic [3:0] ADDR_CMP2_LO    = 4'hB;
  localparam logic [3:0] ADDR_MODE       = 4'hC;
  // Control-one field positions
  localparam int BIT_CAP_IE  = 7;
  localparam int BIT_CMP_IE  = 6;
  localparam int BIT_OVF_IE  = 5;
  localparam int BIT_FORCE2  = 4;
  localparam int BIT_FORCE1  = 3;
  localparam int BIT_LEVEL2  = 2;
  localparam int BIT_EDGE1   = 1;
  localparam int BIT_LEVEL1  = 0;
  // Flag register positions
  localparam int BIT_CAP1_F  = 7;
  localparam int BIT_CMP1_F  = 6;
  localparam int BIT_OVF_F   = 5;
  localparam int BIT_CAP2_F  = 4;
  localparam int BIT_CMP2_F  = 3;
  // Mode register positions (own choice)
  localparam int BIT_PIN1_EN = 7;
  localparam int BIT_PIN2_EN = 6;
  localparam int BIT_ONEPLS  = 5;
  localparam int BIT_PWM     = 4;
  localparam int BIT_EDGE2   = 1;
  // Reset values, count maximum and one-pulse capture value
  localparam logic [7:0]  CTRL_ONE_RST = 8'h00;
  localparam logic [7:0]  MODE_RST     = 8'h00;
  localparam logic [15:0] CNT_RST      = 16'hFFFC;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [15:0] CAP_OPM_VAL  = 16'hFFFD;
  localparam logic [15:0] CMP_RST      = 16'hFFFF;

  // Bus request bundle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tmr_bus_s;

  // Power state seen by the timer
  typedef enum logic [1:0] {
    TMR_RUN,
    TMR_WAIT,
    TMR_HALT
  } tmr_power_e;
endpackage

/* File: hdl/tmr_ctrl.sv */
// Timer core with low-power behaviour, interrupt request and control register one
`timescale 1ns/1ps
module tmr_ctrl
  import tmr_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  input  wire tmr_bus_s   bus_in,
  output logic      [7:0] rdata_out,
  input  wire logic       wait_mode_in,
  input  wire logic       halt_mode_in,
  input  wire logic       global_mask_in,
  input  wire logic       cap_one_pin_in,
  input  wire logic       cap_two_pin_in,
  output logic            cmp_one_pin_out,
  output logic            cmp_one_pin_en_out,
  output logic            cmp_two_pin_out,
  output logic            cmp_two_pin_en_out,
  output logic            irq_out,
  output logic            wake_out
);

  // ****************************************************************
  // Pin synchronisers and power state
  // ****************************************************************
  logic [1:0] cap1_sync;
  logic [1:0] cap2_sync;
  logic [1:0] halt_sync;
  logic       cap1_prev;
  logic       cap2_prev;
  logic       halt_prev;
  tmr_power_e power;

  // Capture pins and halt level come from outside; two stages before use
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cap1_sync <= 2'h0;
      cap2_sync <= 2'h0;
      halt_sync <= 2'h0;
      cap1_prev <= 1'b0;
      cap2_prev <= 1'b0;
      halt_prev <= 1'b0;
    end else begin
      cap1_sync <= {cap1_sync[0], cap_one_pin_in};
      cap2_sync <= {cap2_sync[0], cap_two_pin_in};
      halt_sync <= {halt_sync[0], halt_mode_in};
      cap1_prev <= cap1_sync[1];
      cap2_prev <= cap2_sync[1];
      halt_prev <= halt_sync[1];
    end
  end

  // Wait has no effect on timer logic; it is tracked only for the wake output
  always_comb begin
    if (halt_sync[1]) begin
      power = TMR_HALT;
    end else if (wait_mode_in) begin
      power = TMR_WAIT;
    end else begin
      power = TMR_RUN;
    end
  end

  // ****************************************************************
  // Registers and bus decode
  // ****************************************************************
  logic [7:0]  ctrl_one;
  logic [7:0]  mode;
  logic [7:0]  flags;
  logic [15:0] cnt;
  logic [15:0] cap1;
  logic [15:0] cap2;
  logic [15:0] cmp1;
  logic [15:0] cmp2;
  logic [15:0] cmp1_act;
  logic [15:0] cmp2_act;
  logic [1:0]  armed;
  logic [7:0]  flags_seen;
  logic        cmp1_hold;
  logic        cmp2_hold;

  function automatic logic hit(input tmr_bus_s b, input logic [3:0] a);
    hit = (b.wr | b.rd) && (b.addr == a);
  endfunction

  logic halted;
  logic halt_exit;
  logic pwm_on;
  logic opm_on;
  logic edge1;
  logic edge2;
  logic cmp1_match;
  logic cmp2_match;
  logic ovf;
  logic period;
  logic [15:0] next_cnt;

  assign halted    = halt_sync[1];
  assign halt_exit = halt_prev && !halt_sync[1];
  assign pwm_on    = mode[BIT_PWM];
  assign opm_on    = mode[BIT_ONEPLS] && !pwm_on;
  // Polarity select: 1 rising, 0 falling
  assign edge1 = ctrl_one[BIT_EDGE1] ? (cap1_sync[1] && !cap1_prev)
                                     : (!cap1_sync[1] && cap1_prev);
  assign edge2 = mode[BIT_EDGE2] ? (cap2_sync[1] && !cap2_prev) : (!cap2_sync[1] && cap2_prev);
  assign cmp1_match = !halted && !cmp1_hold && (cnt == cmp1_act);
  assign cmp2_match = !halted && !cmp2_hold && (cnt == cmp2_act);
  assign ovf        = !halted && (cnt == CNT_MAX);
  assign period     = pwm_on && cmp2_match;

  // Counter stops during halt, resumes from held value
  always_comb begin
    next_cnt = cnt;
    if (!halted) begin
      if (period || (opm_on && edge1)) begin
        next_cnt = CNT_RST;
      end else if (hit(bus_in, ADDR_CNT_LO) && bus_in.wr) begin
        next_cnt = CNT_RST;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= CNT_RST;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Control one: plain eight-bit read-write, zero at reset
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_one <= CTRL_ONE_RST;
      mode     <= MODE_RST;
    end else if (!halted && bus_in.wr) begin
      if (bus_in.addr == ADDR_CTRL_ONE) begin
        ctrl_one <= bus_in.wdata;
      end
      if (bus_in.addr == ADDR_MODE) begin
        mode <= bus_in.wdata;
      end
    end
  end

  // Compare values; high-byte write inhibits compare until low byte lands
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmp1      <= CMP_RST;
      cmp2      <= CMP_RST;
      cmp1_act  <= CMP_RST;
      cmp2_act  <= CMP_RST;
      cmp1_hold <= 1'b0;
      cmp2_hold <= 1'b0;
    end else if (!halted) begin
      if (bus_in.wr && bus_in.addr == ADDR_CMP1_HI) begin
        cmp1[15:8] <= bus_in.wdata;
        cmp1_hold  <= 1'b1;
      end
      if (bus_in.wr && bus_in.addr == ADDR_CMP1_LO) begin
        cmp1[7:0] <= bus_in.wdata;
        cmp1_hold <= 1'b0;
      end
      if (bus_in.wr && bus_in.addr == ADDR_CMP2_HI) begin
        cmp2[15:8] <= bus_in.wdata;
        cmp2_hold  <= 1'b1;
      end
      if (bus_in.wr && bus_in.addr == ADDR_CMP2_LO) begin
        cmp2[7:0] <= bus_in.wdata;
        cmp2_hold <= 1'b0;
      end
      // PWM double-buffers the compare values up to the period end
      if (!pwm_on || period) begin
        cmp1_act <= cmp1;
        cmp2_act <= cmp2;
      end
    end
  end

  // ****************************************************************
  // Capture and flags
  // ****************************************************************
  // Capture edges during halt arm detection, resolved at exit
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      armed <= 2'h0;
      cap1  <= 16'h0000;
      cap2  <= 16'h0000;
    end else begin
      if (halted) begin
        armed <= armed | {edge2, edge1 && !pwm_on && !opm_on};
      end else begin
        armed <= 2'h0;
      end
      if (!halted && (armed[0] || (edge1 && !pwm_on && !opm_on))) begin
        cap1 <= cnt;
      end else if (!halted && opm_on && edge1) begin
        cap1 <= CAP_OPM_VAL;
      end
      if (!halted && (armed[1] || edge2)) begin
        cap2 <= cnt;
      end
    end
  end

  // Flags: set beats clear; clear needs flags read first
  logic [7:0] set_f;
  logic [7:0] clr_f;
  always_comb begin
    set_f = 8'h00;
    clr_f = 8'h00;
    if (!halted) begin
      set_f[BIT_CAP1_F] = armed[0] || (edge1 && !pwm_on) || period;
      set_f[BIT_CAP2_F] = armed[1] || edge2;
      set_f[BIT_CMP1_F] = cmp1_match && !pwm_on && !opm_on && !ctrl_one[BIT_FORCE1];
      set_f[BIT_CMP2_F] = cmp2_match && !pwm_on && !ctrl_one[BIT_FORCE2];
      set_f[BIT_OVF_F]  = ovf;
      clr_f[BIT_CAP1_F] = flags_seen[BIT_CAP1_F] && hit(bus_in, ADDR_CAP1_LO);
      clr_f[BIT_CAP2_F] = flags_seen[BIT_CAP2_F] && hit(bus_in, ADDR_CAP2_LO);
      clr_f[BIT_CMP1_F] = flags_seen[BIT_CMP1_F] && hit(bus_in, ADDR_CMP1_LO);
      clr_f[BIT_CMP2_F] = flags_seen[BIT_CMP2_F] && hit(bus_in, ADDR_CMP2_LO);
      clr_f[BIT_OVF_F]  = flags_seen[BIT_OVF_F] && hit(bus_in, ADDR_CNT_LO);
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags      <= 8'h00;
      flags_seen <= 8'h00;
    end else begin
      flags <= (flags & ~clr_f) | set_f;
      if (!halted && bus_in.rd && bus_in.addr == ADDR_FLAGS) begin
        flags_seen <= flags;
      end else begin
        flags_seen <= flags_seen & ~clr_f;
      end
    end
  end

  // ****************************************************************
  // Interrupt request and wake
  // ****************************************************************
  logic pend;
  assign pend = (ctrl_one[BIT_CAP_IE] && (flags[BIT_CAP1_F] || flags[BIT_CAP2_F]))
             || (ctrl_one[BIT_CMP_IE] && (flags[BIT_CMP1_F] || flags[BIT_CMP2_F]))
             || (ctrl_one[BIT_OVF_IE] && flags[BIT_OVF_F]);

  // Wake only from wait; flags cannot change in halt anyway
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out  <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      irq_out  <= pend && !global_mask_in;
      wake_out <= pend && !global_mask_in && (power == TMR_WAIT);
    end
  end

  // ****************************************************************
  // Compare pins
  // ****************************************************************
  // Enables only gate the pins; compare logic runs regardless
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmp_one_pin_out    <= 1'b0;
      cmp_two_pin_out    <= 1'b0;
      cmp_one_pin_en_out <= 1'b1;
      cmp_two_pin_en_out <= 1'b1;
    end else begin
      cmp_one_pin_en_out <= !mode[BIT_PIN1_EN];
      cmp_two_pin_en_out <= !mode[BIT_PIN2_EN];
      if (!halted) begin
        if (pwm_on || opm_on) begin
          if (period || (opm_on && edge1)) begin
            cmp_one_pin_out <= ctrl_one[BIT_LEVEL2];
          end else if (cmp1_match) begin
            cmp_one_pin_out <= ctrl_one[BIT_LEVEL1];
          end
        end else if (ctrl_one[BIT_FORCE1] || cmp1_match) begin
          cmp_one_pin_out <= ctrl_one[BIT_LEVEL1];
        end
        if (!opm_on && !pwm_on && (ctrl_one[BIT_FORCE2] || cmp2_match)) begin
          cmp_two_pin_out <= ctrl_one[BIT_LEVEL2];
        end
      end
    end
  end

  // ****************************************************************
  // Read port, data one cycle after strobe
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        ADDR_CTRL_ONE: rdata_out <= ctrl_one;
        ADDR_MODE:     rdata_out <= mode;
        ADDR_FLAGS:    rdata_out <= flags;
        ADDR_CNT_HI:   rdata_out <= cnt[15:8];
        ADDR_CNT_LO:   rdata_out <= cnt[7:0];
        ADDR_CAP1_HI:  rdata_out <= cap1[15:8];
        ADDR_CAP1_LO:  rdata_out <= cap1[7:0];
        ADDR_CAP2_HI:  rdata_out <= cap2[15:8];
        ADDR_CAP2_LO:  rdata_out <= cap2[7:0];
        ADDR_CMP1_HI:  rdata_out <= cmp1[15:8];
        ADDR_CMP1_LO:  rdata_out <= cmp1[7:0];
        ADDR_CMP2_HI:  rdata_out <= cmp2[15:8];
        ADDR_CMP2_LO:  rdata_out <= cmp2[7:0];
        default:       rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule

/* File: tb/tmr_properties.sv */
// Port checker for the timer control block, bound to its top module
`timescale 1ns/1ps
module tmr_properties
  import tmr_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  input  wire tmr_bus_s   bus_in,
  input  wire logic [7:0] rdata_out,
  input  wire logic       wait_mode_in,
  input  wire logic       halt_mode_in,
  input  wire logic       global_mask_in,
  input  wire logic       cmp_one_pin_out,
  input  wire logic       cmp_one_pin_en_out,
  input  wire logic       cmp_two_pin_out,
  input  wire logic       irq_out,
  input  wire logic       wake_out
);
  // ********
  // Shadows
  // ********
  logic [1:0] halt_sync;
  logic [7:0] ctrl_copy;
  logic [7:0] mode_copy;
  logic       pulse_mode;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  // Same two-stage halt view as the block, so writes dropped in halt are dropped here too
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      halt_sync <= 2'b00;
    end else begin
      halt_sync <= {halt_sync[0], halt_mode_in};
    end
  end

  // Copies of what software wrote
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_copy <= CTRL_ONE_RST;
      mode_copy <= MODE_RST;
    end else if (bus_in.wr && !halt_sync[1]) begin
      if (bus_in.addr == ADDR_CTRL_ONE) begin
        ctrl_copy <= bus_in.wdata;
      end
      if (bus_in.addr == ADDR_MODE) begin
        mode_copy <= bus_in.wdata;
      end
    end
  end

  // Forcing is void in the pulse modes
  assign pulse_mode = mode_copy[BIT_ONEPLS] | mode_copy[BIT_PWM];

  // ***********
  // Properties
  // ***********
  property p_ctrl_read; bus_in.rd && bus_in.addr == ADDR_CTRL_ONE |=> rdata_out == $past(ctrl_copy); endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control one read back differs");
  property p_force_one;
    (mode_copy[BIT_PIN1_EN] && ctrl_copy[BIT_FORCE1] && !pulse_mode)[*2] ##0 $stable(ctrl_copy)
      |-> cmp_one_pin_out == ctrl_copy[BIT_LEVEL1];
  endproperty
  a_force_one: assert property (p_force_one) else $error("pin one ignores forced level");
  property p_force_two;
    (mode_copy[BIT_PIN2_EN] && ctrl_copy[BIT_FORCE2] && !pulse_mode)[*2] ##0 $stable(ctrl_copy)
      |-> cmp_two_pin_out == ctrl_copy[BIT_LEVEL2];
  endproperty
  a_force_two: assert property (p_force_two) else $error("pin two ignores forced level");
  property p_pin_en; mode_copy[BIT_PIN1_EN] [*2] |-> !cmp_one_pin_en_out; endproperty
  a_pin_en: assert property (p_pin_en) else $error("pin one not driven while enabled");
  property p_mask; global_mask_in |=> !irq_out; endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  property p_irq_off; (ctrl_copy[7:5] == 3'b000) [*2] |-> !irq_out; endproperty
  a_irq_off: assert property (p_irq_off) else $error("request with all enables clear");
  property p_wake_wait; !wait_mode_in |=> !wake_out; endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("wake outside wait");
  property p_wake_halt; halt_mode_in [*4] |-> !wake_out; endproperty
  a_wake_halt: assert property (p_wake_halt) else $error("wake during halt");
  property p_wake_irq; wake_out |-> irq_out; endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake without request");
  c_irq: cover property ($rose(irq_out));
  c_wake: cover property ($rose(wake_out));
  c_force: cover property (ctrl_copy[BIT_FORCE1] && mode_copy[BIT_PIN1_EN]);
endmodule

bind tmr_ctrl tmr_properties tmr_properties_inst (
  .clk_sys_in(clk_sys_in),
  .arst_n_in(arst_n_in),
  .bus_in(bus_in),
  .rdata_out(rdata_out),
  .wait_mode_in(wait_mode_in),
  .halt_mode_in(halt_mode_in),
  .global_mask_in(global_mask_in),
  .cmp_one_pin_out(cmp_one_pin_out),
  .cmp_one_pin_en_out(cmp_one_pin_en_out),
  .cmp_two_pin_out(cmp_two_pin_out),
  .irq_out(irq_out),
  .wake_out(wake_out)
);

/* File: tb/tmr_cpu.sv */
// Model of the CPU core: register port master and power levels
`timescale 1ns/1ps
module tmr_cpu
  import tmr_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] rdata_in,
  output tmr_bus_s        bus_out,
  output logic            wait_out,
  output logic            halt_out,
  output logic            mask_out
);
  // Idle bus, running and unmasked core at time zero
  initial begin
    bus_out  = '0;
    wait_out = 1'b0;
    halt_out = 1'b0;
    mask_out = 1'b0;
  end

  // Levels change right after an edge
  task automatic set_power(input logic w, input logic h, input logic m);
    wait_out <= w;
    halt_out <= h;
    mask_out <= m;
    @(posedge clk_sys_in);
  endtask

  // A quiet cycle follows each strobe so one edge never sees two assignments
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_in);
    bus_out <= '0;
    @(posedge clk_sys_in);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_in);
    bus_out <= '0;
    #1;
    d = rdata_in;
    @(posedge clk_sys_in);
  endtask

  // Flag clear: status first, then the matching low byte
  task automatic clr(input logic [3:0] lo);
    logic [7:0] junk;
    rd(ADDR_FLAGS, junk);
    rd(lo, junk);
  endtask
endmodule

/* File: tb/test_tmr_ctrl.sv */
// Self-checking bench for the timer control block
`timescale 1ns/1ps
module test_tmr_ctrl;
  import tmr_pkg::*;
  logic       clk_sys_in;
  logic       arst_n_in;
  tmr_bus_s   bus;
  logic [7:0] rdata;
  logic       wait_m;
  logic       halt_m;
  logic       mask;
  logic       cap_one;
  logic       cap_two;
  logic       p1;
  logic       e1;
  logic       p2;
  logic       e2;
  logic       irq;
  logic       wake;
  logic [7:0] d;
  logic [7:0] seen;
  logic [7:0] held;
  int         n_fail;
  int         checks_done;
  logic [7:0] pats [4] = '{8'hFF, 8'hA5, 8'h5A, 8'h00};
  logic [7:0] fctl [4] = '{8'h09, 8'h08, 8'h14, 8'h10};
  logic [7:0] fpin [4] = '{8'h01, 8'h00, 8'h02, 8'h00};

  tmr_cpu tmr_cpu_inst (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .bus_out(bus), .wait_out(wait_m),
    .halt_out(halt_m), .mask_out(mask));
  tmr_ctrl tmr_ctrl_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .bus_in(bus), .rdata_out(rdata),
    .wait_mode_in(wait_m), .halt_mode_in(halt_m), .global_mask_in(mask), .cap_one_pin_in(cap_one),
    .cap_two_pin_in(cap_two), .cmp_one_pin_out(p1), .cmp_one_pin_en_out(e1), .cmp_two_pin_out(p2),
    .cmp_two_pin_en_out(e2), .irq_out(irq), .wake_out(wake));

  // 250 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Outputs are sampled mid-cycle, away from the edge that updates them
  task automatic snap(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    seen = {2'b00, wake, irq, e2, e1, p2, p1};
    @(posedge clk_sys_in);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Sequence needs a few hundred cycles; the limit is far above that
  initial begin
    #40000;
    n_fail++;
    print_verdict();
  end

  initial begin
    arst_n_in <= 1'b0;
    cap_one <= 1'b0;
    cap_two <= 1'b0;
    n_fail = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    tmr_cpu_inst.rd(ADDR_CTRL_ONE, d);
    chk("ctrl_reset", CTRL_ONE_RST, d);
    foreach (pats[i]) begin
      tmr_cpu_inst.wr(ADDR_CTRL_ONE, pats[i]);
      tmr_cpu_inst.rd(ADDR_CTRL_ONE, d);
      chk("ctrl_rw", pats[i], d);
    end
    tmr_cpu_inst.rd(4'hD, d);
    chk("unmapped", 8'h00, d);
    // Counter wrapped past the reset compare values: overflow and both compare flags
    tmr_cpu_inst.rd(ADDR_FLAGS, d);
    chk("boot_flags", 8'h68, d);
    snap(1);
    chk("irq_none", 8'h00, seen & 8'h10);
    tmr_cpu_inst.wr(ADDR_CTRL_ONE, 8'h20);
    snap(1);
    chk("irq_ovf", 8'h10, seen & 8'h10);
    tmr_cpu_inst.set_power(1'b0, 1'b0, 1'b1);
    snap(1);
    chk("irq_masked", 8'h00, seen & 8'h10);
    tmr_cpu_inst.set_power(1'b0, 1'b0, 1'b0);
    tmr_cpu_inst.clr(ADDR_CNT_LO);
    snap(1);
    chk("irq_ovf_gone", 8'h00, seen & 8'h10);
    tmr_cpu_inst.wr(ADDR_CTRL_ONE, 8'h40);
    snap(1);
    chk("irq_cmp", 8'h10, seen & 8'h10);
    tmr_cpu_inst.clr(ADDR_CMP1_LO);
    snap(1);
    chk("irq_cmp_two", 8'h10, seen & 8'h10);
    tmr_cpu_inst.clr(ADDR_CMP2_LO);
    snap(1);
    chk("irq_cmp_gone", 8'h00, seen & 8'h10);
    // Capture edge polarity, both settings
    tmr_cpu_inst.wr(ADDR_CTRL_ONE, 8'h80);
    cap_one <= 1'b1;
    snap(6);
    chk("rise_ignored", 8'h00, seen & 8'h10);
    cap_one <= 1'b0;
    snap(6);
    chk("fall_capture", 8'h10, seen & 8'h10);
    tmr_cpu_inst.clr(ADDR_CAP1_LO);
    tmr_cpu_inst.wr(ADDR_CTRL_ONE, 8'h82);
    cap_one <= 1'b1;
    snap(6);
    chk("rise_capture", 8'h10, seen & 8'h10);
    tmr_cpu_inst.set_power(1'b1, 1'b0, 1'b0);
    snap(1);
    chk("wake_wait", 8'h30, seen & 8'h30);
    tmr_cpu_inst.set_power(1'b1, 1'b1, 1'b0);
    snap(4);
    chk("wake_halt", 8'h00, seen & 8'h20);
    // Halt ends two edges after the level drops; a flags read before that is ignored
    tmr_cpu_inst.set_power(1'b0, 1'b0, 1'b0);
    snap(2);
    tmr_cpu_inst.clr(ADDR_CAP1_LO);
    tmr_cpu_inst.rd(ADDR_FLAGS, d);
    chk("cap_clear", 8'h00, d & 8'h80);
    // Halt: write dropped, count frozen, edge armed and captured at exit
    tmr_cpu_inst.set_power(1'b0, 1'b1, 1'b0);
    snap(4);
    tmr_cpu_inst.rd(ADDR_CNT_LO, held);
    tmr_cpu_inst.wr(ADDR_CTRL_ONE, 8'h00);
    cap_one <= 1'b0;
    snap(6);
    cap_one <= 1'b1;
    snap(6);
    tmr_cpu_inst.rd(ADDR_CNT_LO, d);
    chk("halt_count", held, d);
    tmr_cpu_inst.set_power(1'b0, 1'b0, 1'b0);
    snap(4);
    tmr_cpu_inst.rd(ADDR_CTRL_ONE, d);
    chk("halt_write", 8'h82, d);
    tmr_cpu_inst.rd(ADDR_FLAGS, d);
    chk("halt_capture", 8'h80, d & 8'h80);
    tmr_cpu_inst.rd(ADDR_CAP1_LO, d);
    chk("halt_cap_value", held, d);
    // Pins: enables, forced levels, then real matches
    tmr_cpu_inst.clr(ADDR_CAP1_LO);
    tmr_cpu_inst.wr(ADDR_MODE, 8'hC0);
    snap(2);
    chk("pin_enables", 8'h00, seen & 8'h0C);
    foreach (fctl[i]) begin
      tmr_cpu_inst.wr(ADDR_CTRL_ONE, fctl[i]);
      snap(2);
      chk("forced_pins", fpin[i], seen & 8'h03);
    end
    tmr_cpu_inst.wr(ADDR_CTRL_ONE, 8'h05);
    tmr_cpu_inst.wr(ADDR_CNT_LO, 8'h00);
    snap(8);
    chk("match_pins", 8'h03, seen & 8'h03);
    // Level two differs from level one so the period match shows on pin one
    tmr_cpu_inst.wr(ADDR_CTRL_ONE, 8'h01);
    tmr_cpu_inst.wr(ADDR_MODE, 8'hD0);
    tmr_cpu_inst.clr(ADDR_CMP1_LO);
    tmr_cpu_inst.clr(ADDR_CMP2_LO);
    tmr_cpu_inst.wr(ADDR_CNT_LO, 8'h00);
    snap(8);
    chk("pwm_pins", 8'h02, seen & 8'h03);
    tmr_cpu_inst.rd(ADDR_FLAGS, d);
    chk("pwm_flags", 8'h80, d & 8'hC8);
    print_verdict();
  end
endmodule
